/* pmx_port_mux.sv */
// top: pin-function multiplexing for the address/data port, the alternate port and aux pins
//
// Overview of operation
// R1 - reset loads ones, quasi mode, first port
// R2 - second port eight bits, reset ones, quasi
// R3 - each pin configured independently, own behaviour
// R4 - bus16: high byte muxed with A12-A19
// R5 - bus8: programmable number of address lines
// R6 - verify: first port inputs low address
// R7 - programmer drives high address on port
// R8 - second port bit0 serial0 receive input
// R9 - second port bit1 serial0 transmit output
// R10 - second port bit2 external irq zero
// R11 - second port bit3 external irq one
// R12 - bit4 timer zero count or overflow
// R13 - aux bit5 serial1 transmit output
// R14 - aux pin timer two count or clockout
// R15 - aux bit4 serial1 receive input
`timescale 1ns/1ps
`default_nettype none
module pmx_port_mux (
	input wire logic ref_clk,
	input wire logic rst,
	input wire pmx_pkg::pmx_mode_e mode,
	input wire logic addr_phase,
	input wire logic [19:0] bus_addr,
	input wire logic [7:0] bus_data_hi,
	input wire logic bus_data_oe,
	input wire logic [3:0] addr_lines,
	input wire logic latch_we,
	input wire logic [7:0] latch2_wdata,
	input wire logic [7:0] latch3_wdata,
	input wire logic [7:0] aux_wdata,
	input wire logic cfg_we,
	input wire logic [15:0] cfg2_wdata,
	input wire logic [15:0] cfg3_wdata,
	input wire logic [15:0] cfga_wdata,
	input wire logic [7:0] alt3_en,
	input wire logic [7:0] alta_en,
	input wire logic serial0_transmit_out,
	input wire logic timer_zero_ovf_out,
	input wire logic timer_zero_out_en,
	input wire logic serial1_transmit_out,
	input wire logic timer_two_clockout,
	input wire logic timer_two_out_en,
	input wire logic [7:0] port2_in,
	input wire logic [7:0] port3_in,
	input wire logic [7:0] aux_in,
	output logic [7:0] port2_out,
	output logic [7:0] port2_oe,
	output logic [7:0] port3_out,
	output logic [7:0] port3_oe,
	output logic [7:0] aux_out,
	output logic [7:0] aux_oe,
	output logic [7:0] port2_read_r,
	output logic [7:0] port3_read_r,
	output logic [7:0] verify_addr_lo_r,
	output logic [7:0] verify_addr_hi_r,
	output logic [7:0] bus_data_in_r,
	output pmx_pkg::pmx_alt_in_s alt_in_r
);
	//////////////////////////////////////////////////////////////////////////////
	// latches and configuration
	logic [7:0] lat2_r, lat2_nxt, lat3_r, lat3_nxt, lata_r, lata_nxt;
	logic [15:0] cfg2_r, cfg2_nxt, cfg3_r, cfg3_nxt, cfga_r, cfga_nxt;
	always_comb begin
		lat2_nxt = lat2_r;
		lat3_nxt = lat3_r;
		lata_nxt = lata_r;
		cfg2_nxt = cfg2_r;
		cfg3_nxt = cfg3_r;
		cfga_nxt = cfga_r;
		if (latch_we) begin
			lat2_nxt = latch2_wdata;
			lat3_nxt = latch3_wdata;
			lata_nxt = aux_wdata;
		end
		if (cfg_we) begin
			cfg2_nxt = cfg2_wdata;
			cfg3_nxt = cfg3_wdata;
			cfga_nxt = cfga_wdata;
		end
	end
	// reset: all latches ones, every pin quasi-bidirectional
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lat2_r <= pmx_pkg::LATCH_RST; // R1
			cfg2_r <= pmx_pkg::CFG_RST; // R1
			lat3_r <= pmx_pkg::LATCH_RST; // R2
			cfg3_r <= pmx_pkg::CFG_RST; // R2
			lata_r <= pmx_pkg::LATCH_RST;
			cfga_r <= pmx_pkg::CFG_RST;
		end else begin
			lat2_r <= lat2_nxt;
			lat3_r <= lat3_nxt;
			lata_r <= lata_nxt;
			cfg2_r <= cfg2_nxt;
			cfg3_r <= cfg3_nxt;
			cfga_r <= cfga_nxt;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// first port: bus ownership by mode
	logic [7:0] addr_mask;
	logic [7:0] bus_val;
	logic bus_own;
	logic [7:0] bus_own_mask;
	always_comb begin
		addr_mask = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < addr_lines) addr_mask[i] = 1'b1; // R5
		end
		bus_val = lat2_r;
		bus_own = 1'b0;
		bus_own_mask = 8'h00;
		case (mode)
			pmx_pkg::PMX_BUS16: begin
				bus_own = 1'b1;
				bus_own_mask = 8'hFF;
				bus_val = addr_phase ? bus_addr[19:12] : bus_data_hi; // R4
			end
			pmx_pkg::PMX_BUS8: begin
				bus_own = 1'b1;
				bus_own_mask = addr_mask; // R5
				bus_val = (bus_addr[19:12] & addr_mask) | (lat2_r & ~addr_mask);
			end
			pmx_pkg::PMX_VERIFY: bus_own = 1'b0; // R6
			default: bus_own = 1'b0;
		endcase
	end
	//////////////////////////////////////////////////////////////////////////////
	// per-pin drivers; each pin reads its own two config bits
	logic [7:0] p2_o, p2_e, p3_o, p3_e, pa_o, pa_e;
	logic [7:0] p3_val, pa_val;
	always_comb begin
		p3_val = lat3_r;
		if (alt3_en[pmx_pkg::BIT_SER0_TX]) begin
			p3_val[pmx_pkg::BIT_SER0_TX] = serial0_transmit_out; // R9
		end
		if (alt3_en[pmx_pkg::BIT_TMR0] && timer_zero_out_en) begin
			p3_val[pmx_pkg::BIT_TMR0] = timer_zero_ovf_out; // R12
		end
		pa_val = lata_r;
		if (alta_en[pmx_pkg::BIT_SER1_TX]) begin
			pa_val[pmx_pkg::BIT_SER1_TX] = serial1_transmit_out; // R13
		end
		if (alta_en[pmx_pkg::BIT_TMR2] && timer_two_out_en) begin
			pa_val[pmx_pkg::BIT_TMR2] = timer_two_clockout; // R14
		end
	end
	for (genvar g = 0; g < pmx_pkg::PORT_W; g++) begin : g_pin
		pmx_pin_cell u_p2 (.cfg(cfg2_r[2*g+1:2*g]), .dval(lat2_r[g]), // R3
			.pad_out(p2_o[g]), .pad_oe(p2_e[g]));
		pmx_pin_cell u_p3 (.cfg(cfg3_r[2*g+1:2*g]), .dval(p3_val[g]), // R3
			.pad_out(p3_o[g]), .pad_oe(p3_e[g]));
		pmx_pin_cell u_pa (.cfg(cfga_r[2*g+1:2*g]), .dval(pa_val[g]),
			.pad_out(pa_o[g]), .pad_oe(pa_e[g]));
	end
	//////////////////////////////////////////////////////////////////////////////
	// output selection and input capture
	logic [7:0] p2_out_nxt, p2_oe_nxt, p3_out_nxt, p3_oe_nxt;
	logic [7:0] vlo_nxt, vhi_nxt, bdin_nxt, pa_oe_nxt;
	pmx_pkg::pmx_alt_in_s alt_nxt;
	always_comb begin
		p2_out_nxt = p2_o;
		p2_oe_nxt = p2_e;
		if (bus_own) begin
			for (int i = 0; i < 8; i++) begin
				if (bus_own_mask[i]) begin
					p2_out_nxt[i] = bus_val[i];
					// bus16 data phase drives only on writes, read data flows inward; bus8 address lines drive in every phase
					p2_oe_nxt[i] = addr_phase | bus_data_oe | (mode == pmx_pkg::PMX_BUS8); // R4
				end
			end
		end
		if (mode == pmx_pkg::PMX_VERIFY) p2_oe_nxt = 8'h00; // R6
		p3_out_nxt = p3_o;
		p3_oe_nxt = p3_e;
		// inputs used by alternate functions must not be driven by the port
		if (alt3_en[pmx_pkg::BIT_SER0_RX]) p3_oe_nxt[pmx_pkg::BIT_SER0_RX] = 1'b0; // R8
		if (alt3_en[pmx_pkg::BIT_IRQ0]) p3_oe_nxt[pmx_pkg::BIT_IRQ0] = 1'b0; // R10
		if (alt3_en[pmx_pkg::BIT_IRQ1]) p3_oe_nxt[pmx_pkg::BIT_IRQ1] = 1'b0; // R11
		if (alt3_en[pmx_pkg::BIT_TMR0] && !timer_zero_out_en) begin
			p3_oe_nxt[pmx_pkg::BIT_TMR0] = 1'b0; // R12
		end
		if (mode == pmx_pkg::PMX_VERIFY) p3_oe_nxt = 8'h00; // R7
		// aux input roles release their pins whatever the pin setting says
		pa_oe_nxt = pa_e;
		if (alta_en[pmx_pkg::BIT_SER1_RX]) pa_oe_nxt[pmx_pkg::BIT_SER1_RX] = 1'b0; // R15
		if (alta_en[pmx_pkg::BIT_TMR2] && !timer_two_out_en) begin
			pa_oe_nxt[pmx_pkg::BIT_TMR2] = 1'b0; // R14
		end
		vlo_nxt = verify_addr_lo_r;
		vhi_nxt = verify_addr_hi_r;
		if (mode == pmx_pkg::PMX_VERIFY) begin
			vlo_nxt = port2_in; // R6
			vhi_nxt = port3_in; // R7
		end
		bdin_nxt = port2_in;
		alt_nxt.serial0_receive_in = port3_in[pmx_pkg::BIT_SER0_RX]; // R8
		alt_nxt.external_irq_zero_in = port3_in[pmx_pkg::BIT_IRQ0]; // R10
		alt_nxt.external_irq_one_in = port3_in[pmx_pkg::BIT_IRQ1]; // R11
		alt_nxt.timer_zero_count_in = port3_in[pmx_pkg::BIT_TMR0]; // R12
		alt_nxt.serial1_receive_in = aux_in[pmx_pkg::BIT_SER1_RX]; // R15
		alt_nxt.timer_two_count_in = aux_in[pmx_pkg::BIT_TMR2]; // R14
	end
	// all pad outputs registered; reset releases pins (quasi high = weak one)
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			port2_out <= pmx_pkg::LATCH_RST;
			port2_oe <= 8'h00;
			port3_out <= pmx_pkg::LATCH_RST;
			port3_oe <= 8'h00;
			aux_out <= pmx_pkg::LATCH_RST;
			aux_oe <= 8'h00;
			port2_read_r <= 8'h00;
			port3_read_r <= 8'h00;
			verify_addr_lo_r <= 8'h00;
			verify_addr_hi_r <= 8'h00;
			bus_data_in_r <= 8'h00;
			alt_in_r <= '0;
		end else begin
			port2_out <= p2_out_nxt;
			port2_oe <= p2_oe_nxt;
			port3_out <= p3_out_nxt;
			port3_oe <= p3_oe_nxt;
			aux_out <= pa_o;
			aux_oe <= pa_oe_nxt; // R15
			port2_read_r <= port2_in;
			port3_read_r <= port3_in;
			verify_addr_lo_r <= vlo_nxt;
			verify_addr_hi_r <= vhi_nxt;
			bus_data_in_r <= bdin_nxt;
			alt_in_r <= alt_nxt;
		end
	end
endmodule
`default_nettype wire

/* pmx_pkg.sv */
// package: constants and carrier types for the two-port pin-function mux
package pmx_pkg;
	localparam int PORT_W = 8;
	localparam logic [7:0] LATCH_RST = 8'hFF;
	localparam logic [1:0] CFG_QUASI = 2'h0;
	localparam logic [1:0] CFG_PUSHPULL = 2'h1;
	localparam logic [1:0] CFG_OPENDRAIN = 2'h2;
	localparam logic [1:0] CFG_INPUT = 2'h3;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam int BIT_SER0_RX = 0;
	localparam int BIT_SER0_TX = 1;
	localparam int BIT_IRQ0 = 2;
	localparam int BIT_IRQ1 = 3;
	localparam int BIT_TMR0 = 4;
	localparam int BIT_SER1_RX = 4;
	localparam int BIT_SER1_TX = 5;
	localparam int BIT_TMR2 = 0;
	localparam logic [3:0] ADDR_LINES_RST = 4'h8;
	typedef enum logic [1:0] {PMX_USER, PMX_BUS16, PMX_BUS8, PMX_VERIFY} pmx_mode_e;
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} pmx_pad_s;
	typedef struct packed {
		logic serial0_receive_in;
		logic external_irq_zero_in;
		logic external_irq_one_in;
		logic timer_zero_count_in;
		logic serial1_receive_in;
		logic timer_two_count_in;
	} pmx_alt_in_s;
endpackage

/* pmx_pin_cell.sv */
// one configurable port pin: output driver per mode
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_cell (
	input wire logic [1:0] cfg,
	input wire logic dval,
	output logic pad_out,
	output logic pad_oe
);
	// quasi drives ones weakly; modelled as drive only when low or strong push-pull
	always_comb begin
		pad_out = dval;
		case (cfg)
			pmx_pkg::CFG_QUASI: pad_oe = ~dval;
			pmx_pkg::CFG_PUSHPULL: pad_oe = 1'b1;
			pmx_pkg::CFG_OPENDRAIN: pad_oe = ~dval;
			pmx_pkg::CFG_INPUT: pad_oe = 1'b0;
			default: pad_oe = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* pmx_checker.sv */
// checker: timing relations at the pin mux ports
`timescale 1ns/1ps
`default_nettype none
module pmx_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire pmx_pkg::pmx_mode_e mode,
	input wire logic addr_phase,
	input wire logic [19:0] bus_addr,
	input wire logic [7:0] alt3_en,
	input wire logic serial0_transmit_out,
	input wire logic [7:0] port2_in,
	input wire logic [7:0] port3_in,
	input wire logic [7:0] aux_in,
	input wire logic [7:0] port2_out,
	input wire logic [7:0] port2_oe,
	input wire logic [7:0] port3_out,
	input wire logic [7:0] port3_oe,
	input wire logic [7:0] verify_addr_lo_r,
	input wire logic [7:0] port2_read_r,
	input wire logic [7:0] port3_read_r,
	input wire logic [7:0] bus_data_in_r,
	input wire pmx_pkg::pmx_alt_in_s alt_in_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////
	// upper address byte; the first port carries it in bus address phases
	wire logic [7:0] a_hi = bus_addr[19:12];
	property p_rst;
		disable iff (1'b0) rst |=> {port2_out, port3_out, port2_oe, port3_oe} == 32'hFFFF0000;
	endproperty
	property p_bus16;
		mode == pmx_pkg::PMX_BUS16 && addr_phase |=> port2_out == $past(a_hi) && port2_oe == 8'hFF;
	endproperty
	property p_verify;
		mode == pmx_pkg::PMX_VERIFY |=> verify_addr_lo_r == $past(port2_in) && port2_oe == 8'h00;
	endproperty
	property p_rx0;
		alt3_en[0] |=> !port3_oe[0] && alt_in_r.serial0_receive_in == $past(port3_in[0]);
	endproperty
	property p_tx0;
		alt3_en[1] && mode != pmx_pkg::PMX_VERIFY |=> port3_out[1] == $past(serial0_transmit_out);
	endproperty
	property p_irq0;
		alt3_en[2] |=> !port3_oe[2] && alt_in_r.external_irq_zero_in == $past(port3_in[2]);
	endproperty
	property p_irq1;
		alt3_en[3] |=> !port3_oe[3] && alt_in_r.external_irq_one_in == $past(port3_in[3]);
	endproperty
	property p_rx1;
		$changed(aux_in[4]) |=> alt_in_r.serial1_receive_in == $past(aux_in[4]);
	endproperty
	property p_t0in;
		alt3_en[4] |=> alt_in_r.timer_zero_count_in == $past(port3_in[4]);
	endproperty
	// pin samples follow the pins one cycle later
	property p_sample;
		1'b1 |=> {port2_read_r, port3_read_r, bus_data_in_r} == $past({port2_in, port3_in, port2_in});
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_bus16: assert property (p_bus16) else $error("bus16 address wrong");
	a_verify: assert property (p_verify) else $error("verify capture wrong");
	a_rx0: assert property (p_rx0) else $error("serial0 receive wrong");
	a_tx0: assert property (p_tx0) else $error("serial0 transmit wrong");
	a_irq0: assert property (p_irq0) else $error("irq zero wrong");
	a_irq1: assert property (p_irq1) else $error("irq one wrong");
	a_rx1: assert property (p_rx1) else $error("serial1 receive wrong");
	a_t0in: assert property (p_t0in) else $error("timer zero input wrong");
	a_sample: assert property (p_sample) else $error("pin sample wrong");
	c_bus16: cover property (mode == pmx_pkg::PMX_BUS16 && addr_phase);
	c_verify: cover property (mode == pmx_pkg::PMX_VERIFY);
	c_alt: cover property (alt3_en[1] && serial0_transmit_out);
	c_bus8: cover property (mode == pmx_pkg::PMX_BUS8 && addr_phase);
endmodule
`default_nettype wire

/* pmx_prog_model.sv */
// programmer model: drives address bytes onto both ports while verifying
`timescale 1ns/1ps
`default_nettype none
module pmx_prog_model (
	input wire logic ref_clk,
	input wire pmx_pkg::pmx_mode_e mode,
	input wire logic [15:0] prog_addr,
	output logic [7:0] port2_in,
	output logic [7:0] port3_in
);
	logic [7:0] idle_r = 8'h5A;
	// released pins wander so a stale value never passes for a capture
	always @(posedge ref_clk) idle_r <= ~idle_r ^ 8'h01;
	always_comb begin
		port2_in = idle_r;
		port3_in = ~idle_r;
		if (mode == pmx_pkg::PMX_VERIFY) begin
			port2_in = prog_addr[7:0];
			port3_in = prog_addr[15:8];
		end
	end
endmodule
`default_nettype wire

/* test_port2_port3_pin_function_mux.sv */
// testbench: port mux with programmer model and checker
`timescale 1ns/1ps
`default_nettype none
module test_port2_port3_pin_function_mux;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	pmx_pkg::pmx_mode_e mode = pmx_pkg::PMX_USER;
	logic addr_phase = 1'b0, bus_data_oe = 1'b0, latch_we = 1'b0, cfg_we = 1'b0;
	logic serial0_transmit_out = 1'b0, timer_zero_ovf_out = 1'b0, timer_zero_out_en = 1'b0;
	logic serial1_transmit_out = 1'b0, timer_two_clockout = 1'b0, timer_two_out_en = 1'b0;
	logic [19:0] bus_addr = 20'h00000;
	logic [15:0] prog_addr = 16'h0000, cfg3 = 16'h0000, lfsr = 16'h32B6;
	logic [7:0] bus_data_hi = 8'h00, l2 = 8'hFF, l3 = 8'hFF, alt3_en = 8'h00, alta_en = 8'h00;
	logic [7:0] aux_in = 8'h00, m;
	logic [3:0] addr_lines = 4'h8;
	wire logic [7:0] port2_in, port3_in, port2_out, port2_oe, port3_out, port3_oe, aux_out, aux_oe;
	wire logic [7:0] verify_addr_lo_r, verify_addr_hi_r;
	wire pmx_pkg::pmx_alt_in_s alt_in_r;
	int failures = 0, total_checks = 0;
	////////////////////////////////
	pmx_port_mux i_dut (.ref_clk, .rst, .mode, .addr_phase, .bus_addr, .bus_data_hi, .bus_data_oe,
		.addr_lines, .latch_we, .latch2_wdata(l2), .latch3_wdata(l3), .aux_wdata(l2), .cfg_we,
		.cfg2_wdata(cfg3), .cfg3_wdata(cfg3), .cfga_wdata(~cfg3), .alt3_en, .alta_en,
		.serial0_transmit_out, .timer_zero_ovf_out, .timer_zero_out_en, .serial1_transmit_out,
		.timer_two_clockout, .timer_two_out_en, .port2_in, .port3_in, .aux_in, .port2_out,
		.port2_oe, .port3_out, .port3_oe, .aux_out, .aux_oe, .port2_read_r(), .port3_read_r(),
		.verify_addr_lo_r, .verify_addr_hi_r, .bus_data_in_r(), .alt_in_r);
	pmx_prog_model i_prog (.ref_clk, .mode, .prog_addr, .port2_in, .port3_in);
	// 50 ns period
	always #25 ref_clk = ~ref_clk;
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// expected drive enable per pin from its two-bit setting
	function automatic logic [7:0] exp_oe(input logic [15:0] c, input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			exp_oe[i] = c[2*i+:2] == pmx_pkg::CFG_PUSHPULL ? 1'b1 :
				c[2*i+:2] == pmx_pkg::CFG_INPUT ? 1'b0 : ~v[i];
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (2000) @(posedge ref_clk);
		failures++;
		end_sim();
	end
	////////////////////////////////
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("port2 reset", {port2_out, port2_oe}, 16'hFF00);
		check("port3 reset", {port3_out, port3_oe}, 16'hFF00);
		repeat (6) begin
			@(posedge ref_clk);
			lfsr = nxt(lfsr);
			{l2, l3} <= {lfsr[15:8], lfsr[7:0]};
			cfg3 <= nxt(lfsr);
			{latch_we, cfg_we} <= 2'h3;
			@(posedge ref_clk);
			{latch_we, cfg_we} <= 2'h0;
			@(posedge ref_clk);
			#1;
			check("port3 pins", {port3_out, port3_oe}, {l3, exp_oe(cfg3, l3)});
			check("port2 pins", {port2_out, port2_oe}, {l2, exp_oe(cfg3, l2)});
			check("aux pins", {aux_out, aux_oe}, {l2, exp_oe(~cfg3, l2)});
		end
		repeat (8) begin
			@(posedge ref_clk);
			lfsr = nxt(lfsr);
			mode <= pmx_pkg::PMX_BUS16;
			{bus_data_oe, addr_phase} <= lfsr[1:0];
			{bus_addr, bus_data_hi} <= {lfsr, lfsr[3:0], lfsr[7:0] ^ 8'hA5};
			@(posedge ref_clk);
			#1;
			// read data phases must leave the pins released
			m = addr_phase ? bus_addr[19:12] : bus_data_hi;
			check("bus16", {port2_out, port2_oe}, {m, {8{addr_phase | bus_data_oe}}});
		end
		for (int n = 0; n <= 8; n++) begin
			@(posedge ref_clk);
			mode <= pmx_pkg::PMX_BUS8;
			{addr_phase, addr_lines} <= {1'b1, n[3:0]};
			@(posedge ref_clk);
			#1;
			m = 8'((9'h001 << n) - 9'h001);
			check("bus8", port2_out, (bus_addr[19:12] & m) | (l2 & ~m));
		end
		repeat (4) begin
			@(posedge ref_clk);
			lfsr = nxt(lfsr);
			mode <= pmx_pkg::PMX_VERIFY;
			prog_addr <= lfsr;
			@(posedge ref_clk);
			#1;
			check("verify low", {verify_addr_lo_r, port2_oe}, {prog_addr[7:0], 8'h00});
			check("verify high", {verify_addr_hi_r, port3_oe}, {prog_addr[15:8], 8'h00});
		end
		repeat (10) begin
			@(posedge ref_clk);
			lfsr = nxt(lfsr);
			mode <= pmx_pkg::PMX_USER;
			{alt3_en, alta_en, aux_in} <= {8'hFF, 8'hFF, lfsr[15:8]};
			{serial0_transmit_out, timer_zero_ovf_out, timer_zero_out_en} <= lfsr[2:0];
			{serial1_transmit_out, timer_two_clockout, timer_two_out_en} <= lfsr[5:3];
			@(posedge ref_clk);
			#1;
			check("tx0", port3_out[1], serial0_transmit_out);
			m[0] = timer_zero_out_en & timer_zero_ovf_out;
			check("timer0 out", timer_zero_out_en ? port3_out[4] : port3_oe[4], m[0]);
			check("tx1", aux_out[5], serial1_transmit_out);
			m[0] = timer_two_out_en & timer_two_clockout;
			check("timer2 out", timer_two_out_en ? aux_out[0] : aux_oe[0], m[0]);
			check("timer2 in", alt_in_r.timer_two_count_in, aux_in[0]);
			check("rx1 oe", aux_oe[4], 1'b0);
		end
		// second reset in mid-run must bring back ones and quasi pins
		@(posedge ref_clk);
		rst <= 1'b1;
		{alt3_en, alta_en} <= 16'h0000;
		@(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("port2 rerun reset", {port2_out, port2_oe}, 16'hFF00);
		check("port3 rerun reset", {port3_out, port3_oe}, 16'hFF00);
		end_sim();
	end
endmodule
bind pmx_port_mux pmx_checker i_chk (.ref_clk, .rst, .mode, .addr_phase, .bus_addr, .alt3_en,
	.serial0_transmit_out, .port2_in, .port3_in, .aux_in, .port2_out, .port2_oe, .port3_out,
	.port3_oe, .verify_addr_lo_r, .port2_read_r, .port3_read_r, .bus_data_in_r, .alt_in_r);
`default_nettype wire
